// ===== dsg_clock_gate.sv
// Deep-sleep clock gating register with mode selection, unit fault and interrupt logic
// Function
// - Gate register sits at 0x120, resets to 0x00000040.
// - Set bit clocks its unit; clear bit leaves it unclocked, disabled.
// - Access to an unclocked unit is answered with a bus fault.
// - Bit 16 is read-write converter 0 deep-sleep enable, resets 0.
// - Bit 6 is read-write hibernation deep-sleep enable, resets 1.
// - Bit 3 is read-write watchdog deep-sleep enable, resets 0.
// - All other bits are read-only zero; software preserves them.
// - Enables used in deep-sleep only; sleep gating needs auto-gating select.
`timescale 1ns/100ps
module dsg_clock_gate
  import dsg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  input wire dsg_gate_t run_clock_gate_0,
  input wire dsg_gate_t sleep_clock_gate_0,
  input wire dsg_gate_t unit_access,
  output dsg_gate_t unit_clock_enable,
  output dsg_gate_t unit_bus_fault,
  output logic irq
);

  dsg_state_t s_q;
  dsg_state_t s_d;
  dsg_mode_t mode;
  logic acc_done;
  logic [31:0] lanes;
  logic [31:0] rdata;
  logic hit;

  // ----------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------
  always_comb begin
    if (deep_sleep_mode) begin
      mode = DSG_MODE_DEEP;
    end else if (sleep_mode) begin
      mode = DSG_MODE_SLEEP;
    end else begin
      mode = DSG_MODE_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    unique case (paddr)
      DSG_DCG0_OFS: rdata = dsg_pack(s_q.dcg);
      DSG_AUTO_OFS: rdata[DSG_AUTO_BIT] = s_q.autogate;
      DSG_STAT_OFS: rdata = dsg_pack(s_q.stat);
      DSG_CLR_OFS: rdata = 32'h00000000;
      DSG_IEN_OFS: rdata = dsg_pack(s_q.ien);
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One wait state: pready comes from a flop, so the access phase is two cycles
  assign acc_done = psel & penable & s_q.pready;
  assign lanes = dsg_lanes(pstrb);

  always_comb begin
    s_d = s_q;
    s_d.pready = psel & penable & ~s_q.pready;
    if (psel & penable & ~s_q.pready) begin
      s_d.pslverr = ~hit;
      s_d.prdata = pwrite ? 32'h00000000 : rdata;
    end else begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h00000000;
    end

    // Unpack keeps only the three enables, so reserved bits never land
    if (acc_done & pwrite & hit) begin
      unique case (paddr)
        DSG_DCG0_OFS: s_d.dcg = dsg_unpack((dsg_pack(s_q.dcg) & ~lanes) | (pwdata & lanes));
        DSG_AUTO_OFS: if (pstrb[0]) s_d.autogate = pwdata[DSG_AUTO_BIT];
        DSG_IEN_OFS: s_d.ien = dsg_unpack((dsg_pack(s_q.ien) & ~lanes) | (pwdata & lanes));
        default: s_d.autogate = s_q.autogate;
      endcase
    end

    // Deep-sleep uses this register; sleep gating only with auto-gating select
    unique case (mode)
      DSG_MODE_DEEP: s_d.clk_en = s_q.dcg;
      DSG_MODE_SLEEP: s_d.clk_en = s_q.autogate ? sleep_clock_gate_0 : run_clock_gate_0;
      DSG_MODE_RUN: s_d.clk_en = run_clock_gate_0;
    endcase

    // Faults judged against the enable the unit actually sees this cycle
    s_d.fault = unit_access & ~s_q.clk_en;

    // Set wins over a same-cycle clear
    s_d.stat = s_q.stat;
    if (acc_done & pwrite & (paddr == DSG_CLR_OFS)) begin
      s_d.stat = s_q.stat & ~dsg_unpack(pwdata & lanes);
    end
    s_d.stat = s_d.stat | s_d.fault;
    s_d.irq = |(s_d.stat & s_d.ien);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.dcg <= DSG_GATE_RST;
      s_q.autogate <= DSG_AUTO_RST;
      s_q.stat <= '0;
      s_q.ien <= '0;
      s_q.clk_en <= DSG_GATE_RST;
      s_q.fault <= '0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h00000000;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign unit_clock_enable = s_q.clk_en;
  assign unit_bus_fault = s_q.fault;
  assign irq = s_q.irq;

endmodule // dsg_clock_gate

// ===== dsg_pkg.sv
// Package: offsets, field layout, reset values and types of the deep-sleep clock gate block
package dsg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] DSG_DCG0_OFS = 12'h120;
  localparam logic [11:0] DSG_AUTO_OFS = 12'h130;
  localparam logic [11:0] DSG_STAT_OFS = 12'h140;
  localparam logic [11:0] DSG_CLR_OFS = 12'h144;
  localparam logic [11:0] DSG_IEN_OFS = 12'h148;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DSG_ADC_BIT = 16;
  localparam int DSG_HIBER_BIT = 6;
  localparam int DSG_WDOG_BIT = 3;
  localparam int DSG_AUTO_BIT = 0;
  localparam logic [31:0] DSG_DCG0_RST = 32'h00000040;
  localparam logic DSG_AUTO_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic adc;
    logic hiber;
    logic wdog;
  } dsg_gate_t;

  // Enables after reset: only the hibernation unit clocked, matches 0x00000040
  localparam dsg_gate_t DSG_GATE_RST = 3'h2;

  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_t;

  typedef struct packed {
    dsg_gate_t dcg;
    logic autogate;
    dsg_gate_t stat;
    dsg_gate_t ien;
    dsg_gate_t clk_en;
    dsg_gate_t fault;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } dsg_state_t;

  // ----------------------------------------------------------------
  // Layout helpers
  // ----------------------------------------------------------------
  // Only the three enable positions exist; all else reads zero
  function automatic logic [31:0] dsg_pack(input dsg_gate_t g);
    logic [31:0] w;
    w = 32'h00000000;
    w[DSG_ADC_BIT] = g.adc;
    w[DSG_HIBER_BIT] = g.hiber;
    w[DSG_WDOG_BIT] = g.wdog;
    return w;
  endfunction

  function automatic dsg_gate_t dsg_unpack(input logic [31:0] w);
    dsg_gate_t g;
    g.adc = w[DSG_ADC_BIT];
    g.hiber = w[DSG_HIBER_BIT];
    g.wdog = w[DSG_WDOG_BIT];
    return g;
  endfunction

  function automatic logic [31:0] dsg_lanes(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ===== dsg_clock_gate_asserts.sv
// Port assertions for the deep-sleep clock gate
`timescale 1ns/100ps
module dsg_chk
  import dsg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsg_gate_t unit_access,
  input wire dsg_gate_t unit_clock_enable,
  input wire dsg_gate_t unit_bus_fault,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_data: assert property (!pready |-> prdata == 32'h00000000)
    else $error("stray read data");
  a_fault_raise: assert property ((unit_access & ~unit_clock_enable) != 3'h0
    |=> unit_bus_fault == $past(unit_access & ~unit_clock_enable))
    else $error("fault missing");
  a_fault_cause: assert property (unit_bus_fault != 3'h0
    |-> $past(unit_access & ~unit_clock_enable) == unit_bus_fault)
    else $error("fault without cause");
  a_irq_clear: assert property ($fell(irq)
    |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("irq dropped without write");
  cover property (unit_bus_fault != 3'h0);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule // dsg_chk
bind dsg_clock_gate dsg_chk u_dsg_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_access(unit_access),
  .unit_clock_enable(unit_clock_enable), .unit_bus_fault(unit_bus_fault), .irq(irq));

// ===== dsg_clock_gate_tb.sv
// Self-checking bench for the deep-sleep clock gate
`timescale 1ns/100ps
module dsg_clock_gate_tb
  import dsg_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slp = 1'b0, dsl = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, irq, er;
  dsg_gate_t rg = 3'h0, sg = 3'h0, ua = 3'h0, ce, bf;
  int miscompares = 0, n_checks = 0, cyc = 0;
  dsg_clock_gate u_dsg_clock_gate(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(slp), .deep_sleep_mode(dsl), .run_clock_gate_0(rg),
    .sleep_clock_gate_0(sg), .unit_access(ua), .unit_clock_enable(ce), .unit_bus_fault(bf), .irq(irq));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_fields;
    apb(0, 12'h120, 0);
    chk(rd, 32'h00000040);
    chk(ce, 3'h2);
    apb(1, 12'h120, 32'hFFFFFFFF);
    apb(0, 12'h120, 0);
    chk(rd, 32'h00010048);
    chk(ce, 3'h7);
    apb(1, 12'h120, 32'hFFFEFFB7);
    apb(0, 12'h120, 0);
    chk(rd, 32'h00000000);
    chk(ce, 3'h0);
  endtask
  task t_fault;
    apb(1, 12'h148, 32'h00000008);
    ua <= 3'h1;
    @(posedge pclk);
    ua <= 3'h0;
    @(posedge pclk);
    chk(bf, 3'h1);
    chk(irq, 1'h1);
    apb(0, 12'h140, 0);
    chk(rd, 32'h00000008);
    apb(1, 12'h144, 32'h00000008);
    apb(0, 12'h140, 0);
    chk(rd, 32'h00000000);
    chk(irq, 1'h0);
  endtask
  task t_sleep;
    dsl <= 1'b0;
    slp <= 1'b1;
    rg <= 3'h1;
    sg <= 3'h4;
    apb(0, 12'h124, 0);
    chk(er, 1'h1);
    chk(ce, 3'h1);
    apb(1, 12'h130, 32'h00000001);
    apb(0, 12'h130, 0);
    chk(rd, 32'h00000001);
    chk(ce, 3'h4);
    slp <= 1'b0;
    apb(0, 12'h130, 0);
    chk(ce, 3'h1);
  endtask
  task stop_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling far above the few dozen cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_fields();
    t_fault();
    t_sleep();
    stop_test();
  end
endmodule // dsg_clock_gate_tb
